/* File: logic/sramc_pkg.sv */
// shared constants and types for the asynchronous static memory controller
package sramc_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int TMR_W  = 12;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int PWRUP_WAIT_US  = 200;   // wait after supply settles
   localparam int RECOVER_NS     = 45;    // recovery after retention
   localparam int PWRUP_CYC      = (PWRUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_RAW    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC    = (RECOVER_RAW < 1) ? 1 : RECOVER_RAW;
   localparam logic [TMR_W-1:0] PWRUP_LOAD   = TMR_W'(PWRUP_CYC);
   localparam logic [TMR_W-1:0] RECOVER_LOAD = TMR_W'(RECOVER_CYC);

   // ----------------------------------------
   // reset values of the pins
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // ----------------------------------------
   // controller states, gray on each access step except the return to idle
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_PWR_WAIT = 4'h0,
      ST_PWR_CNT  = 4'h1,
      ST_IDLE     = 4'h3,
      ST_RD_ACC   = 4'h2,
      ST_RD_END   = 4'h6,
      ST_WR_SET   = 4'h7,
      ST_WR_PUL   = 4'h5,
      ST_WR_END   = 4'h4,
      ST_RETAIN   = 4'hc,
      ST_RECOVER  = 4'hd
   } sramc_state_t;
endpackage

/* File: logic/sramc_tmr_if.sv */
// interface between the controller and its wait timer
`timescale 1ns/1ps
interface sramc_tmr_if;
   logic                         load;      // start a new wait
   logic [sramc_pkg::TMR_W-1:0]  load_val;  // cycles to wait
   logic                         done;      // wait expired

   modport ctl (output load, output load_val, input done);
   modport tmr (input load, input load_val, output done);
endinterface

/* File: logic/sramc_timer.sv */
// down counter that times the power-up and recovery waits
`timescale 1ns/1ps
module sramc_timer (
   input  wire logic  clk_i,   // system clock
   input  wire logic  rst_i,   // synchronous reset, high
   sramc_tmr_if.tmr   tmr      // load and done
);
   logic [sramc_pkg::TMR_W-1:0] cnt;

   // ----------------------------------------
   // count down to zero after a load
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 12'h000;
      end else if (tmr.load) begin
         cnt <= tmr.load_val;
      end else if (cnt != 12'h000) begin
         cnt <= cnt - 12'h001;
      end
   end

   assign tmr.done = (cnt == 12'h000) && !tmr.load;
endmodule

/* File: logic/sramc_ctrl.sv */
// host controller that drives an asynchronous 256k x 8 static memory
// ----------------------------------------
// Behaviour
// - write strobe goes low only while both selects are active.
// - data setup and hold are measured against the write-ending edge.
// - address stable at least 35 ns before the write ends.
// - address valid at least 0 ns before the write starts.
// - address held at least 0 ns after the write ends.
// - write data driven at least 25 ns before the write ends.
// - write data held at least 0 ns after the write ends.
// - wait 200 us after supply settles before any access.
// - deselect the memory before the supply drops into retention.
// - after retention wait for supply, then 45 ns before accesses.
// ----------------------------------------
`timescale 1ns/1ps
module sramc_ctrl (
   input  wire logic                         clk_i,         // 10 MHz clock
   input  wire logic                         rst_i,         // synchronous reset, high
   input  wire logic                         req_valid_i,   // access request
   input  wire logic                         req_write_i,   // 1 write, 0 read
   input  wire logic [sramc_pkg::ADDR_W-1:0] req_addr_i,    // access address
   input  wire logic [sramc_pkg::DATA_W-1:0] req_wdata_i,   // write data
   output logic                              req_ready_o,   // request can be taken
   output logic                              rsp_valid_o,   // read data pulse
   output logic [sramc_pkg::DATA_W-1:0]      rsp_rdata_o,   // read data
   input  wire logic                         supply_ok_i,   // supply ramped and stable
   input  wire logic                         retain_i,      // ask for retention
   output logic                              retain_o,      // safe to lower supply
   output logic [sramc_pkg::ADDR_W-1:0]      mem_addr_o,    // address pins
   output logic                              select_low_active_n_o, // select, low active
   output logic                              select_high_active_o,  // select, high active
   output logic                              write_n_o,     // write strobe, low active
   output logic                              out_gate_n_o,  // output gate, low active
   output logic [sramc_pkg::DATA_W-1:0]      data_o,        // data pins out
   output logic                              data_oe_n_o,   // low while driving data
   input  wire logic [sramc_pkg::DATA_W-1:0] data_i         // data pins in
);
   sramc_pkg::sramc_state_t state;
   sramc_pkg::sramc_state_t next_state;
   logic                    is_write;
   sramc_tmr_if             tmr_if ();

   // ----------------------------------------
   // wait timer
   // ----------------------------------------
   sramc_timer u_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tmr   (tmr_if.tmr)
   );

   // timer loads on entry to the two waits
   assign tmr_if.load = ((state == sramc_pkg::ST_PWR_WAIT) && supply_ok_i) ||
                        ((state == sramc_pkg::ST_RETAIN) && !retain_i && supply_ok_i);
   assign tmr_if.load_val = (state == sramc_pkg::ST_PWR_WAIT) ? sramc_pkg::PWRUP_LOAD
                                                               : sramc_pkg::RECOVER_LOAD;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         sramc_pkg::ST_PWR_WAIT: begin
            if (supply_ok_i) next_state = sramc_pkg::ST_PWR_CNT;
         end
         sramc_pkg::ST_PWR_CNT: begin
            if (tmr_if.done) next_state = sramc_pkg::ST_IDLE;
         end
         sramc_pkg::ST_IDLE: begin
            if (req_valid_i) begin
               next_state = req_write_i ? sramc_pkg::ST_WR_SET : sramc_pkg::ST_RD_ACC;
            end else if (retain_i) begin
               next_state = sramc_pkg::ST_RETAIN;
            end
         end
         sramc_pkg::ST_RD_ACC:  next_state = sramc_pkg::ST_RD_END;
         sramc_pkg::ST_RD_END:  next_state = sramc_pkg::ST_IDLE;
         sramc_pkg::ST_WR_SET:  next_state = sramc_pkg::ST_WR_PUL;
         sramc_pkg::ST_WR_PUL:  next_state = sramc_pkg::ST_WR_END;
         sramc_pkg::ST_WR_END:  next_state = sramc_pkg::ST_IDLE;
         sramc_pkg::ST_RETAIN: begin
            if (!retain_i && supply_ok_i) next_state = sramc_pkg::ST_RECOVER;
         end
         sramc_pkg::ST_RECOVER: begin
            if (tmr_if.done) next_state = sramc_pkg::ST_IDLE;
         end
         default: next_state = sramc_pkg::ST_PWR_WAIT;
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= sramc_pkg::ST_PWR_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // request handshake
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_ready_o <= 1'b0;
         retain_o    <= 1'b0;
      end else begin
         req_ready_o <= (next_state == sramc_pkg::ST_IDLE);
         retain_o    <= (next_state == sramc_pkg::ST_RETAIN);
      end
   end

   // ----------------------------------------
   // selects: active only inside an access
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         select_low_active_n_o <= 1'b1;
         select_high_active_o  <= 1'b0;
      end else begin
         case (next_state)
            sramc_pkg::ST_RD_ACC, sramc_pkg::ST_WR_SET,
            sramc_pkg::ST_WR_PUL, sramc_pkg::ST_WR_END: begin
               select_low_active_n_o <= 1'b0;
               select_high_active_o  <= 1'b1;
            end
            default: begin
               select_low_active_n_o <= 1'b1;
               select_high_active_o  <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // strobes: one cycle write pulse inside the select window
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_n_o    <= 1'b1;
         out_gate_n_o <= 1'b1;
      end else begin
         write_n_o    <= (next_state != sramc_pkg::ST_WR_PUL);
         out_gate_n_o <= (next_state != sramc_pkg::ST_RD_ACC);
      end
   end

   // ----------------------------------------
   // address and write data, latched when a request is taken
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_addr_o <= sramc_pkg::ADDR_RST;
         data_o     <= sramc_pkg::DATA_RST;
         is_write   <= 1'b0;
      end else if (state == sramc_pkg::ST_IDLE && req_valid_i) begin
         mem_addr_o <= req_addr_i;
         data_o     <= req_wdata_i;
         is_write   <= req_write_i;
      end
   end

   // data pins driven from setup through the cycle after the strobe rises
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_oe_n_o <= 1'b1;
      end else begin
         data_oe_n_o <= !((next_state == sramc_pkg::ST_WR_SET) ||
                          (next_state == sramc_pkg::ST_WR_PUL) ||
                          (next_state == sramc_pkg::ST_WR_END));
      end
   end

   // ----------------------------------------
   // read capture one full cycle after address and gate
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= sramc_pkg::DATA_RST;
      end else begin
         rsp_valid_o <= (state == sramc_pkg::ST_RD_ACC) && !is_write;
         if (state == sramc_pkg::ST_RD_ACC) begin
            rsp_rdata_o <= data_i;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [11:0] wait_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || tmr_if.load) begin
         wait_cnt <= 12'h000;
      end else if (wait_cnt != 12'hfff) begin
         wait_cnt <= wait_cnt + 12'h001;
      end
   end

   sequence s_wr_open;
      $fell(write_n_o) && !data_oe_n_o;
   endsequence
   sequence s_wr_close;
      write_n_o && !data_oe_n_o && !select_low_active_n_o && select_high_active_o;
   endsequence

   chk_write_in_select: assert property (
      !write_n_o |-> !select_low_active_n_o && select_high_active_o)
      else $error("write strobe low outside select");
   chk_write_sequence: assert property (
      s_wr_open |=> s_wr_close ##1 (select_low_active_n_o && data_oe_n_o))
      else $error("write did not close with data held");
   chk_addr_before_wr: assert property (
      $fell(write_n_o) |-> $stable(mem_addr_o) && !$past(data_oe_n_o))
      else $error("address or data not set up before strobe");
   chk_addr_hold_wr: assert property (
      $fell(write_n_o) |=> $stable(mem_addr_o) && $stable(data_o))
      else $error("address or data changed at write end");
   chk_pulse_width: assert property (
      $fell(write_n_o) |=> write_n_o ##1 write_n_o)
      else $error("write pulse not one cycle or back to back");
   chk_no_contention: assert property (
      !data_oe_n_o |-> out_gate_n_o)
      else $error("data driven while output gate low");
   chk_read_sample: assert property (
      rsp_valid_o |-> !$past(out_gate_n_o) && !$past(select_low_active_n_o))
      else $error("read sampled without a full access cycle");
   chk_powerup_wait: assert property (
      (state == sramc_pkg::ST_PWR_CNT && next_state == sramc_pkg::ST_IDLE)
      |-> wait_cnt >= 12'(sramc_pkg::PWRUP_CYC - 1))
      else $error("power-up wait too short");
   chk_retain_desel: assert property (
      retain_o |-> select_low_active_n_o && !select_high_active_o)
      else $error("retention with memory selected");
   chk_recover_wait: assert property (
      (state == sramc_pkg::ST_RECOVER && next_state == sramc_pkg::ST_IDLE)
      |-> wait_cnt >= 12'(sramc_pkg::RECOVER_CYC - 1) && supply_ok_i)
      else $error("recovery wait too short");
endmodule

/* File: dv/sramc_mem_model.sv */
// behavioural model of the asynchronous 256k x 8 static memory
`timescale 1ns/1ps
module sramc_mem_model (
   input  wire logic [sramc_pkg::ADDR_W-1:0] addr_i,    // address pins
   input  wire logic                         sel_n_i,   // select, low active
   input  wire logic                         sel_i,     // select, high active
   input  wire logic                         write_n_i, // write strobe, low active
   input  wire logic                         gate_n_i,  // output gate, low active
   input  wire logic [sramc_pkg::DATA_W-1:0] bus_i,     // resolved data pins
   output logic      [sramc_pkg::DATA_W-1:0] q_o,       // value the memory puts out
   output logic                              drive_o    // memory drives the pins
);
   logic [sramc_pkg::DATA_W-1:0] mem [logic [sramc_pkg::ADDR_W-1:0]];
   logic                         selected;
   logic                         wr_act;

   // select decode and write overlap
   assign selected = (sel_n_i === 1'b0) && (sel_i === 1'b1);
   assign wr_act   = selected && (write_n_i === 1'b0);
   assign drive_o  = selected && (write_n_i === 1'b1) && (gate_n_i === 1'b0);

   // store on whichever edge ends the overlap
   // the x to 0 settle at time zero carries no address and is no write
   always @(negedge wr_act) begin
      if (!$isunknown(addr_i)) mem[addr_i] = bus_i;
   end

   // old data lingers briefly, then garbage, then new data when driving
   initial q_o = 8'h00;
   always @(addr_i or drive_o) begin
      q_o <= #10 ~q_o;
      q_o <= #45 (drive_o && mem.exists(addr_i)) ? mem[addr_i] : (drive_o ? 8'h00 : ~q_o);
   end
endmodule

/* File: dv/tb_top.sv */
// self-checking testbench of the static memory controller
`timescale 1ns/1ps
module tb_top;
   logic                         clk_i, rst_i, req_valid_i, req_write_i, supply_ok_i, retain_i;
   logic [sramc_pkg::ADDR_W-1:0] req_addr_i, mem_addr_o, a;
   logic [sramc_pkg::DATA_W-1:0] req_wdata_i, rsp_rdata_o, data_o, mem_q, bus;
   logic                         req_ready_o, rsp_valid_o, retain_o, sel_n, sel, write_n_o;
   logic                         out_gate_n_o, data_oe_n_o, mem_drive, wr_prev;
   logic [sramc_pkg::DATA_W-1:0] shadow [logic [sramc_pkg::ADDR_W-1:0]];
   logic [sramc_pkg::DATA_W-1:0] rq [$];
   logic [25:0]                  wq [$];
   logic [sramc_pkg::ADDR_W-1:0] addrs [8];
   int                           miscompares, tests_run, cyc, take_cyc, wr_len, n, seed;

   sramc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
      .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
      .supply_ok_i(supply_ok_i), .retain_i(retain_i), .retain_o(retain_o),
      .mem_addr_o(mem_addr_o), .select_low_active_n_o(sel_n), .select_high_active_o(sel),
      .write_n_o(write_n_o), .out_gate_n_o(out_gate_n_o), .data_o(data_o),
      .data_oe_n_o(data_oe_n_o), .data_i(bus));
   sramc_mem_model i_mem (.addr_i(mem_addr_o), .sel_n_i(sel_n), .sel_i(sel),
      .write_n_i(write_n_o), .gate_n_i(out_gate_n_o), .bus_i(bus), .q_o(mem_q),
      .drive_o(mem_drive));

   // resolved data pins
   assign bus = (data_oe_n_o === 1'b0) ? data_o : mem_q;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // counts negedges until ready (or retain_o) is high, gives up after bound
   task automatic wait_high(input bit use_retain, input int bound);
      n = 0;
      while ((use_retain ? retain_o : req_ready_o) !== 1'b1) begin
         @(negedge clk_i);
         n++;
         if (n > bound) begin
            miscompares++;
            end_sim();
         end
      end
   endtask

   // one request, notes the expected outcome
   task automatic access(input logic w, input logic [17:0] ad, input logic [7:0] d);
      wait_high(1'b0, 20);
      req_valid_i = 1'b1;
      req_write_i = w;
      req_addr_i  = ad;
      req_wdata_i = d;
      if (w) begin
         shadow[ad] = d;
         wq.push_back({ad, d});
      end else begin
         rq.push_back(shadow.exists(ad) ? shadow[ad] : 8'h00);
      end
      @(negedge clk_i);
      take_cyc    = cyc;
      req_valid_i = 1'b0;
   endtask

   // clock and cycle count
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 1;

   // output watcher
   always @(negedge clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         if (rq.size() == 0) check("rsp_extra", 1, 0);
         else check("rsp_rdata", rsp_rdata_o, rq.pop_front());
         check("rsp_latency", cyc - take_cyc, 1);
      end
      if (write_n_o === 1'b0) begin
         wr_len++;
         check("wr_select", {sel_n, sel, data_oe_n_o, out_gate_n_o}, 4'b0101);
      end
      if (write_n_o === 1'b1 && wr_prev === 1'b0) begin
         if (wq.size() == 0) check("wr_extra", 1, 0);
         else check("wr_pins", {mem_addr_o, data_o, sel_n, sel, data_oe_n_o}, {wq.pop_front(), 3'b010});
         check("wr_pulse", wr_len, 1);
         wr_len = 0;
      end
      check("bus_clash", mem_drive & ~data_oe_n_o, 0);
      if (retain_o === 1'b1) check("retain_desel", {sel_n, sel}, 2'b10);
      wr_prev = write_n_o;
   end

   // timeout guard
   initial begin
      #(100 * 100000);
      miscompares++;
      end_sim();
   end

   initial begin
      {req_valid_i, req_write_i, retain_i, supply_ok_i} = 4'h0;
      {req_addr_i, req_wdata_i, miscompares, tests_run, cyc, wr_len} = '0;
      rst_i = 1'b1;
      wr_prev = 1'b1;
      seed = 3;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      repeat (5) @(negedge clk_i);
      supply_ok_i = 1'b1;
      wait_high(1'b0, 2100);
      check("pwrup_wait", 32'(n >= 2000), 1);
      // boundary and random writes, back to back
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3ffff : 18'($random(seed));
         addrs[i] = a;
         access(1'b1, a, 8'($random(seed)));
      end
      for (int i = 0; i < 8; i++) access(1'b0, addrs[i], 8'h00);
      for (int i = 0; i < 24; i++) access(1'($random(seed)), addrs[i % 8], 8'($random(seed)));
      // retention with a refused write inside it
      wait_high(1'b0, 20);
      retain_i = 1'b1;
      wait_high(1'b1, 3);
      check("retain_ready", req_ready_o, 0);
      req_valid_i = 1'b1;
      req_write_i = 1'b1;
      req_addr_i  = addrs[0];
      req_wdata_i = ~shadow[addrs[0]];
      repeat (2) @(negedge clk_i);
      req_valid_i = 1'b0;
      supply_ok_i = 1'b0;
      repeat (5) @(negedge clk_i);
      supply_ok_i = 1'b1;
      retain_i    = 1'b0;
      wait_high(1'b0, 20);
      check("recover_wait", 32'(n >= 2), 1);
      for (int i = 0; i < 8; i++) access(1'b0, addrs[i], 8'h00);
      repeat (6) @(negedge clk_i);
      check("rsp_drained", rq.size(), 0);
      end_sim();
   end
endmodule
